// ===== design/csi_defs.svh
/*
  Constants of the serial-bus control port: bus addresses, register bank
  layout, power-up values, write masks and link timing.
  Assumes inclusion by both link ends, the link checker and the bench.
*/
`ifndef CSI_DEFS_SVH
`define CSI_DEFS_SVH

`define CSI_WR_ADDR      8'hd2
`define CSI_RD_ADDR      8'hd3
`define CSI_NUM_REGS     8'h08
`define CSI_CTRL_W       56
`define CSI_CTRL_RST     56'h0000dfc7ff0047
`define CSI_CTRL_WMASK   56'hfffffffffff8c7
`define CSI_RDCNT_RST    8'h07
`define CSI_FSL_BIT      0
`define CSI_FSH_BIT      1
`define CSI_ACK_SLOT     4'h8
`define CSI_BYTE_END     4'h9
`define CSI_CLK_NS       20
`define CSI_QTR_NS       100
`define CSI_QTR_CYC      ((`CSI_QTR_NS + `CSI_CLK_NS - 1) / `CSI_CLK_NS)
`define CSI_FIFO_W       8
`define CSI_FIFO_D       4

`endif

// ===== design/csi_pkg.sv
/*
  Types shared by the two link ends: state enumerations and the bit engine's operation kinds.
  Assumes nothing of its surroundings.
*/
package csi_pkg;

  typedef enum {DS_IDLE, DS_ADDR, DS_INDEX, DS_COUNT, DS_WDATA, DS_TX} csi_dev_state_e;

  typedef enum {HS_IDLE, HS_START, HS_ADDR, HS_INDEX, HS_COUNT, HS_WWAIT, HS_WBYTE,
                HS_RSTART, HS_RADDR, HS_RBYTE, HS_STOP} csi_host_state_e;

  typedef enum {EK_BIT, EK_START, EK_STOP} csi_eng_e;

endpackage

// ===== design/csi_link_if.sv
/*
  Two-wire link between host end and device end.
  Assumes pull-ups on both wires: a released wire reads high.
*/
`timescale 1ns/100ps

interface csi_link_if;
  logic scl_oe_n;
  logic scl_o;
  logic h_sda_oe_n;
  logic h_sda_o;
  logic d_sda_oe_n;
  logic d_sda_o;
  logic scl;
  logic sda;

  // wired-and with pull-up
  assign scl = scl_oe_n | scl_o;
  assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

  modport host (output scl_oe_n, scl_o, h_sda_oe_n, h_sda_o, input scl, sda);
  modport dev  (output d_sda_oe_n, d_sda_o, input scl, sda);
endinterface

// ===== design/csi_fifo.sv
/*
  Small first-in first-out buffer with valid/ready on both sides.
  Assumes a power-of-two depth and one clock for both sides.
*/
`timescale 1ns/100ps

module csi_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;
  assign out_data = mem[rp];
  assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp <= wp + 1'b1;
      end
      if (pop) begin
        rp <= rp + 1'b1;
      end
      cnt       <= next_cnt;
      in_ready  <= next_cnt != (AW+1)'(D);
      out_valid <= next_cnt != '0;
    end
  end
endmodule

// ===== design/csi_dev.sv
/*
  Device end of the serial control link: a bus target that takes indexed
  block writes and serves indexed block reads of a byte-wide register bank.
  Byte 0 reads back the two frequency-select straps.
  Assumes scl and sda arrive asynchronous; the host end makes scl.
*/
`timescale 1ns/100ps
`include "csi_defs.svh"

// How it works
// (R1) start then own write address, acknowledged
// (R2) index byte acknowledged, sets first register
// (R3) write count byte acknowledged, sets length
// (R4) each data byte acked, stored consecutively
// (R5) host stops after last counted byte
// (R6) host reads: index, repeated start, read address
// (R7) count byte sent before register contents
// (R8) register bytes sent from consecutive indices
// (R9) host acks every read byte but last
// (R10) host nacks last byte; device releases sda
// (R11) host stops after the final nack
// (R12) byte 0: read-only strap readback, low bits
// (R13) read-only bits kept; foreign addresses ignored
// (R14) index steps per byte, reloads per transfer
module csi_dev
  import csi_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  csi_link_if.dev                     link,
  input  wire logic                   freq_select_low_readback,
  input  wire logic                   freq_select_high_readback,
  output logic      [`CSI_CTRL_W-1:0] ctrl_regs,
  output logic                        wr_strobe
);
  localparam logic [`CSI_CTRL_W-1:0] WMASK = `CSI_CTRL_WMASK;

  csi_dev_state_e state;
  logic [1:0]     scl_sync;
  logic [1:0]     sda_sync;
  logic [1:0]     fs_sync1;
  logic [1:0]     fs_sync2;
  logic           scl_d;
  logic           sda_d;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_det;
  logic           stop_det;
  logic [3:0]     bcnt;
  logic [7:0]     sr;
  logic [7:0]     tx_byte;
  logic [7:0]     idx;
  logic [7:0]     rem;
  logic [7:0]     cnt_last;
  logic           byte_ok;
  logic           addr_slot;
  logic [7:0]     fs_byte;
  logic [7:0]     rd_val;
  logic [5:0]     wr_off;
  logic [7:0]     wr_mask;
  logic [7:0]     wr_val;

  function automatic logic [5:0] byte_off(input logic [7:0] i);
    byte_off = {i[2:0] - 3'd1, 3'b000};
  endfunction

  function automatic logic in_bank(input logic [7:0] i);
    in_bank = (i != 8'h00) && (i < `CSI_NUM_REGS);
  endfunction

  // pins into the clock domain
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      fs_sync1 <= 2'b00;
      fs_sync2 <= 2'b00;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
      fs_sync1 <= {freq_select_high_readback, freq_select_low_readback};
      fs_sync2 <= fs_sync1;
    end
  end

  assign scl_rise  = scl_sync[1] & ~scl_d;
  assign scl_fall  = ~scl_sync[1] & scl_d;
  assign start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_det  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

  // (R12) strap readback byte
  always_comb begin
    fs_byte               = 8'h00;
    fs_byte[`CSI_FSL_BIT] = fs_sync2[0];
    fs_byte[`CSI_FSH_BIT] = fs_sync2[1];
  end

  always_comb begin
    if (idx == 8'h00) begin
      rd_val = fs_byte;
    end else if (in_bank(idx)) begin
      rd_val = ctrl_regs[byte_off(idx) +: 8];
    end else begin
      rd_val = 8'h00;
    end
  end

  // (R13) masked merge keeps reserved bits
  always_comb begin
    wr_off  = byte_off(idx);
    wr_mask = WMASK[wr_off +: 8];
    wr_val  = (ctrl_regs[wr_off +: 8] & ~wr_mask) | (sr & wr_mask);
  end

  // acceptance of the byte just received
  always_comb begin
    case (state)
      DS_ADDR: begin
        // (R13) only own addresses
        byte_ok = (sr == `CSI_WR_ADDR) || (sr == `CSI_RD_ADDR);
      end
      DS_INDEX: begin
        byte_ok = 1'b1;
      end
      DS_COUNT: begin
        byte_ok = 1'b1;
      end
      DS_WDATA: begin
        byte_ok = rem != 8'h00;
      end
      default: begin
        byte_ok = 1'b0;
      end
    endcase
  end

  // bit counter and receive shifter
  always_ff @(posedge clk) begin
    if (rst) begin
      bcnt <= 4'h0;
      sr   <= 8'h00;
    end else if (start_det) begin
      bcnt <= 4'h0;
    end else if (scl_rise) begin
      if (bcnt < `CSI_ACK_SLOT) begin
        sr <= {sr[6:0], sda_sync[1]};
      end
      bcnt <= bcnt + 4'h1;
    end else if (scl_fall && bcnt == `CSI_BYTE_END) begin
      bcnt <= 4'h0;
    end
  end

  // transfer sequencing and register bank
  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= DS_IDLE;
      idx       <= 8'h00;
      rem       <= 8'h00;
      cnt_last  <= `CSI_RDCNT_RST;
      tx_byte   <= 8'h00;
      ctrl_regs <= `CSI_CTRL_RST;
      wr_strobe <= 1'b0;
      addr_slot <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (start_det) begin
        // (R1) every transfer opens with an address
        state     <= DS_ADDR;
        addr_slot <= 1'b0;
      end else if (stop_det) begin
        state <= DS_IDLE;
      end else if (scl_fall && bcnt == `CSI_ACK_SLOT) begin
        case (state)
          DS_ADDR: begin
            if (sr == `CSI_WR_ADDR) begin
              state <= DS_INDEX;
            end else if (sr == `CSI_RD_ADDR) begin
              // (R7) count goes out first
              state     <= DS_TX;
              tx_byte   <= cnt_last;
              addr_slot <= 1'b1;
            end else begin
              state <= DS_IDLE;
            end
          end
          DS_INDEX: begin
            // (R2) (R14) new start index
            idx   <= sr;
            state <= DS_COUNT;
          end
          DS_COUNT: begin
            // (R3) length of the write
            rem      <= sr;
            cnt_last <= sr;
            state    <= DS_WDATA;
          end
          DS_WDATA: begin
            if (rem != 8'h00) begin
              // (R4) (R14) store and step
              if (in_bank(idx)) begin
                ctrl_regs[wr_off +: 8] <= wr_val;
              end
              idx       <= idx + 8'h01;
              rem       <= rem - 8'h01;
              wr_strobe <= 1'b1;
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end else if (scl_rise && bcnt == `CSI_ACK_SLOT && state == DS_TX) begin
        if (addr_slot) begin
          // own ack of the read address, count byte still to go
          addr_slot <= 1'b0;
        end else if (sda_sync[1]) begin
          // (R10) nack ends the read
          state <= DS_IDLE;
        end else begin
          // (R8) (R14) next register, index steps
          tx_byte <= rd_val;
          idx     <= idx + 8'h01;
        end
      end
    end
  end

  // data line drive: low only for ack or a zero bit
  always_ff @(posedge clk) begin
    link.d_sda_o <= 1'b0;
    if (rst || start_det || stop_det) begin
      link.d_sda_oe_n <= 1'b1;
    end else if (scl_fall) begin
      if (bcnt == `CSI_ACK_SLOT) begin
        // (R1) (R2) (R3) (R4) ack slot
        link.d_sda_oe_n <= !(state != DS_TX && byte_ok);
      end else if (bcnt == `CSI_BYTE_END) begin
        // (R10) released unless still sending
        link.d_sda_oe_n <= (state == DS_TX) ? tx_byte[7] : 1'b1;
      end else if (state == DS_TX && bcnt != 4'h0) begin
        link.d_sda_oe_n <= tx_byte[3'(4'h7 - bcnt)];
      end
    end
  end
endmodule

// ===== design/csi_host.sv
/*
  Host end of the serial control link: runs indexed block writes fed from a
  four-word buffer and indexed block reads that return each byte received.
  Makes scl itself by dividing its own clock; the device end answers on sda.
*/
`timescale 1ns/100ps
`include "csi_defs.svh"

module csi_host
  import csi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  csi_link_if.host        link,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_index,
  input  wire logic [7:0] cmd_count,
  output logic            cmd_ready,
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  output logic            rd_valid,
  output logic            rd_first,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nack_err
);
  csi_host_state_e hs;
  csi_eng_e        kind;
  csi_eng_e        go_kind;
  logic            go;
  logic [8:0]      go_bits;
  logic            busy;
  logic            eng_done;
  logic [1:0]      q;
  logic [3:0]      nb;
  logic [8:0]      sh;
  logic [8:0]      rx;
  logic [7:0]      div;
  logic            tick;
  logic [1:0]      sda_sync;
  logic            is_read;
  logic            first_q;
  logic            last_q;
  logic [7:0]      left;
  logic [7:0]      index_q;
  logic            pop;
  logic            buf_valid;
  logic [7:0]      buf_data;

  csi_fifo #(.W(`CSI_FIFO_W), .D(`CSI_FIFO_D)) u_wbuf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_sync <= 2'b11;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // quarter-period divider for scl
  always_ff @(posedge clk) begin
    if (rst || !busy || tick) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end
  assign tick = busy && (div == 8'(`CSI_QTR_CYC - 1));

  // bit engine: start, stop, or nine bits
  always_ff @(posedge clk) begin
    link.scl_o   <= 1'b0;
    link.h_sda_o <= 1'b0;
    eng_done     <= 1'b0;
    if (rst) begin
      busy            <= 1'b0;
      kind            <= EK_STOP;
      q               <= 2'd0;
      nb              <= 4'h0;
      sh              <= 9'h1ff;
      rx              <= 9'h000;
      link.scl_oe_n   <= 1'b1;
      link.h_sda_oe_n <= 1'b1;
    end else if (go) begin
      busy <= 1'b1;
      kind <= go_kind;
      sh   <= go_bits;
      q    <= 2'd0;
      nb   <= 4'h0;
    end else if (tick) begin
      q <= q + 2'd1;
      case (kind)
        EK_BIT: begin
          case (q)
            2'd0: link.h_sda_oe_n <= sh[8];
            2'd1: link.scl_oe_n <= 1'b1;
            2'd2: rx <= {rx[7:0], sda_sync[1]};
            default: begin
              link.scl_oe_n <= 1'b0;
              sh            <= {sh[7:0], 1'b1};
              nb            <= nb + 4'h1;
              if (nb == `CSI_ACK_SLOT) begin
                busy     <= 1'b0;
                eng_done <= 1'b1;
              end
            end
          endcase
        end
        EK_START: begin
          case (q)
            2'd0: link.h_sda_oe_n <= 1'b1;
            2'd1: link.scl_oe_n <= 1'b1;
            2'd2: link.h_sda_oe_n <= 1'b0;
            default: begin
              link.scl_oe_n <= 1'b0;
              busy          <= 1'b0;
              eng_done      <= 1'b1;
            end
          endcase
        end
        default: begin
          case (q)
            2'd0: link.h_sda_oe_n <= 1'b0;
            2'd1: link.scl_oe_n <= 1'b1;
            2'd2: link.h_sda_oe_n <= 1'b1;
            default: begin
              busy     <= 1'b0;
              eng_done <= 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  task automatic issue(input csi_eng_e k, input logic [8:0] b, input csi_host_state_e n);
    go      <= 1'b1;
    go_kind <= k;
    go_bits <= b;
    hs      <= n;
  endtask

  // transfer sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      hs        <= HS_IDLE;
      go        <= 1'b0;
      go_kind   <= EK_STOP;
      go_bits   <= 9'h1ff;
      cmd_ready <= 1'b1;
      rd_valid  <= 1'b0;
      rd_first  <= 1'b0;
      rd_data   <= 8'h00;
      done      <= 1'b0;
      nack_err  <= 1'b0;
      is_read   <= 1'b0;
      first_q   <= 1'b0;
      last_q    <= 1'b0;
      left      <= 8'h00;
      index_q   <= 8'h00;
      pop       <= 1'b0;
    end else begin
      go       <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      pop      <= 1'b0;
      case (hs)
        HS_IDLE: begin
          if (cmd_valid) begin
            is_read   <= cmd_read;
            left      <= cmd_count;
            index_q   <= cmd_index;
            go_bits   <= {cmd_index, 1'b1};
            cmd_ready <= 1'b0;
            nack_err  <= 1'b0;
            go        <= 1'b1;
            go_kind   <= EK_START;
            hs        <= HS_START;
          end
        end
        HS_START: if (eng_done) issue(EK_BIT, {`CSI_WR_ADDR, 1'b1}, HS_ADDR);
        HS_ADDR: begin
          if (eng_done) begin
            nack_err <= rx[0];
            if (rx[0]) issue(EK_STOP, 9'h1ff, HS_STOP);
            else issue(EK_BIT, {index_q, 1'b1}, HS_INDEX);
          end
        end
        HS_INDEX: begin
          if (eng_done) begin
            nack_err <= rx[0];
            if (rx[0]) issue(EK_STOP, 9'h1ff, HS_STOP);
            // (R6) repeated start for a read
            else if (is_read) issue(EK_START, 9'h1ff, HS_RSTART);
            else issue(EK_BIT, {left, 1'b1}, HS_COUNT);
          end
        end
        HS_COUNT: begin
          if (eng_done) begin
            nack_err <= rx[0];
            if (rx[0]) issue(EK_STOP, 9'h1ff, HS_STOP);
            else hs <= HS_WWAIT;
          end
        end
        HS_WWAIT: begin
          // (R5) stop once the count is spent
          if (left == 8'h00) begin
            issue(EK_STOP, 9'h1ff, HS_STOP);
          end else if (buf_valid) begin
            pop  <= 1'b1;
            left <= left - 8'h01;
            issue(EK_BIT, {buf_data, 1'b1}, HS_WBYTE);
          end
        end
        HS_WBYTE: begin
          if (eng_done) begin
            nack_err <= rx[0];
            if (rx[0]) issue(EK_STOP, 9'h1ff, HS_STOP);
            else hs <= HS_WWAIT;
          end
        end
        HS_RSTART: if (eng_done) issue(EK_BIT, {`CSI_RD_ADDR, 1'b1}, HS_RADDR);
        HS_RADDR: begin
          if (eng_done) begin
            nack_err <= rx[0];
            first_q  <= 1'b1;
            last_q   <= left == 8'h00;
            // (R9) (R10) count byte acked unless last
            if (rx[0]) issue(EK_STOP, 9'h1ff, HS_STOP);
            else issue(EK_BIT, {8'hff, left == 8'h00}, HS_RBYTE);
          end
        end
        HS_RBYTE: begin
          if (eng_done) begin
            rd_valid <= 1'b1;
            rd_first <= first_q;
            rd_data  <= rx[8:1];
            first_q  <= 1'b0;
            // (R11) stop follows the final nack
            if (last_q) begin
              issue(EK_STOP, 9'h1ff, HS_STOP);
            end else begin
              // (R9) (R10) nack only the last byte
              left   <= left - 8'h01;
              last_q <= left == 8'h01;
              issue(EK_BIT, {8'hff, left == 8'h01}, HS_RBYTE);
            end
          end
        end
        HS_STOP: begin
          if (eng_done) begin
            cmd_ready <= 1'b1;
            done      <= 1'b1;
            hs        <= HS_IDLE;
          end
        end
        default: hs <= HS_IDLE;
      endcase
    end
  end
endmodule

// ===== verification/csi_link_sva.sv
/*
  Checker of the two-wire link between host end and device end.
  Assumes the link signals are taken straight from the interface, one clock.
*/
`timescale 1ns/100ps
`include "csi_defs.svh"

module csi_link_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_oe_n,
  input wire logic scl_o,
  input wire logic h_sda_oe_n,
  input wire logic h_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic d_sda_o,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic       scl_q;
  logic       sda_q;
  logic       wr_tx;
  logic       rd_tx;
  logic [3:0] rcnt;
  logic [3:0] bnum;
  logic [7:0] shreg;
  wire        rise  = scl & ~scl_q;
  wire        start = scl & scl_q & sda_q & ~sda;

  always_ff @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end

  // bit slot and byte number since the last start
  always_ff @(posedge clk) begin
    if (rst || start) begin
      rcnt <= 4'h0;
      bnum <= 4'h0;
    end else if (rise && rcnt == 4'h9) begin
      rcnt <= 4'h1;
      bnum <= (bnum == 4'hf) ? bnum : bnum + 4'h1;
    end else if (rise) begin
      rcnt <= rcnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rise && rcnt < 4'h8) shreg <= {shreg[6:0], sda};
  end

  // direction of the transfer, from the acked address
  always_ff @(posedge clk) begin
    if (rst || start) begin
      wr_tx <= 1'b0;
      rd_tx <= 1'b0;
    end else if (rise && rcnt == 4'h8 && bnum == 4'h0) begin
      wr_tx <= !sda && shreg == `CSI_WR_ADDR;
      rd_tx <= !sda && shreg == `CSI_RD_ADDR;
    end
  end

  sequence s_ack_slot;
    rise && rcnt == 4'h8;
  endsequence

  property p_addr_ack;
    s_ack_slot ##0 bnum == 4'h0 |-> sda == (shreg[7:1] != 7'h69);
  endproperty
  property p_ctl_ack;
    s_ack_slot ##0 (wr_tx && bnum inside {4'h1, 4'h2}) |-> !sda;
  endproperty
  property p_rd_release;
    s_ack_slot ##0 (rd_tx && bnum != 4'h0) |-> d_sda_oe_n;
  endproperty
  property p_rd_host_off;
    rise && rd_tx && bnum != 4'h0 && rcnt < 4'h8 |-> h_sda_oe_n;
  endproperty
  property p_stable_hi;
    scl && scl_q |-> $stable(d_sda_oe_n);
  endproperty
  property p_reset;
    $fell(rst) |-> scl && sda && d_sda_oe_n && h_sda_oe_n;
  endproperty
  property p_scl_low;
    $fell(scl) |-> !scl [*8];
  endproperty
  property p_od;
    !scl_o && !h_sda_o && !d_sda_o;
  endproperty

  a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
  a_ctl_ack: assert property (p_ctl_ack) else $error("index or count not acked");
  a_rd_release: assert property (p_rd_release) else $error("device holds sda in host ack");
  a_rd_host_off: assert property (p_rd_host_off) else $error("host drives read bit");
  a_stable_hi: assert property (p_stable_hi) else $error("device moved sda while scl high");
  a_reset: assert property (p_reset) else $error("link not released after reset");
  a_scl_low: assert property (p_scl_low) else $error("scl low too short");
  a_od: assert property (p_od) else $error("open drain driven high");
endmodule

// ===== verification/clock_synth_i2c_index_block_rw_tb.sv
/*
  Top bench: host and device ends joined by the link; drives commands, data and straps.
  Assumes the default header constants and a 50 MHz clock.
*/
`timescale 1ns/100ps
`include "csi_defs.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module clock_synth_i2c_index_block_rw_tb
  import csi_pkg::*;
;
  localparam logic [55:0] CR = `CSI_CTRL_RST;
  localparam logic [55:0] WM = `CSI_CTRL_WMASK;
  logic        clk, rst, fsl, fsh, cmd_valid, cmd_read, wr_valid;
  logic [7:0]  cmd_index, cmd_count, wr_data, rd_data, last_cnt;
  logic        cmd_ready, wr_ready, rd_valid, rd_first, done, nack_err, wr_strobe;
  logic [55:0] ctrl_regs;
  logic [7:0]  bank [0:7];
  logic [7:0]  q [$];
  logic [7:0]  wd [$];
  logic [7:0]  wq [$];
  int          err_total, checks, strobes, i, j;
  integer      seed;

  csi_link_if link ();
  csi_dev csi_dev_i (.clk(clk), .rst(rst), .link(link), .freq_select_low_readback(fsl),
    .freq_select_high_readback(fsh), .ctrl_regs(ctrl_regs), .wr_strobe(wr_strobe));
  csi_host csi_host_i (.clk(clk), .rst(rst), .link(link), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_index(cmd_index), .cmd_count(cmd_count), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_first(rd_first),
    .rd_data(rd_data), .done(done), .nack_err(nack_err));
  csi_link_sva csi_link_sva_i (.clk(clk), .rst(rst), .scl_oe_n(link.scl_oe_n), .scl_o(link.scl_o),
    .h_sda_oe_n(link.h_sda_oe_n), .h_sda_o(link.h_sda_o), .d_sda_oe_n(link.d_sda_oe_n),
    .d_sda_o(link.d_sda_o), .scl(link.scl), .sda(link.sda));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) if (wr_strobe === 1'b1) strobes++;

  function automatic logic [7:0] exp_byte(int n);
    if (n == 0) return {6'h00, fsh, fsl};
    return (n < 8) ? bank[n] : 8'h00;
  endfunction

  function automatic logic [55:0] exp_regs();
    logic [55:0] r;
    for (int n = 1; n < 8; n++) r[8*(n-1)+:8] = bank[n];
    return r;
  endfunction

  task automatic finish_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic timeout_hit(string what);
    err_total++;
    $display("MISMATCH %s exp handshake got timeout", what);
    finish_test();
  endtask

  // feeds wq into the host buffer; entered at a falling edge
  task automatic push_all();
    int n;
    foreach (wq[m]) begin
      wr_valid = 1'b1;
      wr_data = wq[m];
      n = 0;
      while (wr_ready !== 1'b1) begin
        @(negedge clk);
        n++;
        if (n > 20000) timeout_hit("wr_ready");
      end
      @(negedge clk);
    end
    wr_valid = 1'b0;
  endtask

  task automatic xfer(logic rd, logic [7:0] idx, logic [7:0] cnt);
    int n, s0, a;
    s0 = strobes;
    q = {};
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 20000) timeout_hit("cmd_ready");
    end
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_index = idx;
    cmd_count = cnt;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) begin
        q.push_back(rd_data);
        `CHK("rd_first", q.size() == 1, rd_first)
      end
      n++;
      if (n > 40000) timeout_hit("done");
    end
    @(negedge clk);
    `CHK("nack_err", 1'b0, nack_err)
    `CHK("idle", 2'b11, {link.scl, link.sda})
    if (rd) begin
      `CHK("rd_len", {1'b0, cnt} + 9'd1, 9'(q.size()))
      `CHK("rd_count", last_cnt, q[0])
      for (a = 0; a < cnt; a++) `CHK("rd_byte", exp_byte(idx + a), q[a+1])
    end else begin
      last_cnt = cnt;
      for (a = idx; a < idx + cnt; a++)
        if (a >= 1 && a <= 7) bank[a] = (bank[a] & ~WM[8*(a-1)+:8]) | (wd[a-idx] & WM[8*(a-1)+:8]);
      `CHK("ctrl_regs", exp_regs(), ctrl_regs)
      if (idx != 8'h00) `CHK("strobes", cnt, 8'(strobes - s0))
    end
  endtask

  task automatic wr_rand(logic [7:0] idx, logic [7:0] cnt);
    wd = {};
    repeat (cnt) wd.push_back(8'($random(seed)));
    wq = wd;
    push_all();
    xfer(1'b0, idx, cnt);
  endtask

  initial begin
    seed = 32'h009e;
    {rst, cmd_valid, cmd_read, wr_valid, fsl, fsh} = 6'h20;
    {cmd_index, cmd_count, wr_data} = 24'h000000;
    {err_total, checks, strobes} = {32'h0, 32'h0, 32'h0};
    for (j = 0; j < 8; j++) bank[j] = (j == 0) ? 8'h00 : CR[8*(j-1)+:8];
    last_cnt = `CSI_RDCNT_RST;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    `CHK("reset_regs", CR, ctrl_regs)
    `CHK("ready", 2'b11, {cmd_ready, wr_ready})
    {fsh, fsl} = 2'($random(seed));
    repeat (4) @(negedge clk);
    xfer(1'b1, 8'h00, 8'h01);
    wd = {};
    repeat (4) wd.push_back(8'($random(seed)));
    wq = wd;
    push_all();
    `CHK("full", 1'b0, wr_ready)
    xfer(1'b0, 8'h01, 8'h04);
    xfer(1'b1, 8'h01, 8'h04);
    wd = {};
    repeat (4) wd.push_back(8'($random(seed)));
    wq = wd[0:0];
    push_all();
    fork
      xfer(1'b0, 8'h04, 8'h04);
      begin
        repeat (1200) @(negedge clk);
        wq = wd[1:3];
        push_all();
      end
    join
    wr_rand(8'h00, 8'h02);
    wr_rand(8'h07, 8'h02);
    xfer(1'b1, 8'h00, 8'h09);
    xfer(1'b1, 8'h03, 8'h00);
    for (i = 0; i < 6; i++) begin
      {fsh, fsl} = 2'($random(seed));
      if ($random(seed) & 1) xfer(1'b1, {5'h00, 3'($random(seed))}, {6'h00, 2'($random(seed))} + 8'h01);
      else wr_rand({5'h00, 3'($random(seed))}, {6'h00, 2'($random(seed))} + 8'h01);
    end
    finish_test();
  end
endmodule
